// >>> hw/src_pkg.sv
// constants and types shared by the reset controller
package src_pkg;
	// release schedule, counted from the first edge after the trigger drops
	localparam int unsigned SRC_SEQ_CYCLES   = 140;
	localparam int unsigned SRC_CLK_REL      = 20;
	localparam int unsigned SRC_FUNC_REL     = 80;
	localparam int unsigned SRC_CNT_W        = 8;
	// length of the self-clearing functional and per-core watchdog resets
	localparam int unsigned SRC_PULSE_CYCLES = 16;
	localparam int unsigned SRC_PULSE_W      = 5;
	// reset values of the software bits
	localparam logic SRC_DBG_INIT  = 1'b0;
	localparam logic SRC_MASK_INIT = 1'b0;
	localparam logic SRC_FUNC_INIT = 1'b0;
	localparam logic SRC_DOM_INIT  = 1'b0;

	typedef enum logic [3:0] {
		SRC_ST_HOLD = 4'h1,
		SRC_ST_CLK  = 4'h2,
		SRC_ST_FUNC = 4'h4,
		SRC_ST_RUN  = 4'h8
	} src_state_e;
endpackage

// >>> hw/src_dom_if.sv
// reset request and synchronised reset of one clock domain
interface src_dom_if #(
	parameter int unsigned NBR = 4
);
	logic           dom_clk;
	logic           dom_req;
	logic [NBR-1:0] br_req;
	logic           dom_rst_n;
	logic [NBR-1:0] br_rst_n;

	modport ctl  (output dom_clk, output dom_req, output br_req,
	              input dom_rst_n, input br_rst_n);
	modport sync (input dom_clk, input dom_req, input br_req,
	              output dom_rst_n, output br_rst_n);
endinterface

// >>> hw/src_dom_sync.sv
// per-domain reset synchroniser: asserts at once, releases on the domain clock
module src_dom_sync #(
	parameter int unsigned NBR = 4
) (
	src_dom_if.sync dif
);
	import src_pkg::*;

	logic [NBR:0] rst_vec;

	// index NBR is the domain root, the rest are its branches
	for (genvar b = 0; b <= NBR; b++) begin : g_sync
		logic       req_b;
		logic [1:0] sh_q;
		if (b == NBR) begin : g_root
			assign req_b = dif.dom_req;
		end else begin : g_branch
			assign req_b = dif.dom_req | dif.br_req[b];
		end
		always_ff @(posedge dif.dom_clk or posedge req_b) begin
			if (req_b) begin
				sh_q <= 2'b00;
			end else begin
				sh_q <= {sh_q[0], 1'b1};
			end
		end
		assign rst_vec[b] = sh_q[1];
	end

	assign dif.dom_rst_n = rst_vec[NBR];
	assign dif.br_rst_n  = rst_vec[NBR-1:0];
endmodule // src_dom_sync

// >>> hw/src_reset_ctrl.sv
// top reset controller: staged release, watchdogs, software and domain resets
module src_reset_ctrl #(
	parameter int unsigned            NCPU      = 2,
	parameter int unsigned            NDOM      = 4,
	parameter int unsigned            NBR       = 4,
	parameter logic [NDOM*NBR-1:0]    BOOT_MASK = '0
) (
	// clock and resets
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 ext_rst_n,
	// watchdog expiry, from outside this clock
	input  wire logic                 gwdt_exp,
	input  wire logic [NCPU-1:0]      cpu_wdt_exp,
	// software configuration write
	input  wire logic                 cfg_we,
	input  wire logic                 cfg_glb_sw_rst,
	input  wire logic                 cfg_func_pulse,
	input  wire logic                 cfg_func_static,
	input  wire logic                 cfg_dbg_rst,
	input  wire logic [NCPU-1:0]      cfg_cpu_dbg_rst,
	input  wire logic                 cfg_gwdt_mask,
	input  wire logic [NCPU-1:0]      cfg_cpu_wdt_mask,
	input  wire logic [NDOM-1:0]      cfg_dom_rst,
	input  wire logic [NDOM*NBR-1:0]  cfg_br_rst,
	// domain clocks
	input  wire logic [NDOM-1:0]      dom_clk,
	// reset outputs
	output logic                      clk_logic_rst_n,
	output logic                      func_rst_n,
	output logic [NCPU-1:0]           cpu_rst_n,
	output logic                      dbg_rst_n,
	output logic [NCPU-1:0]           cpu_dbg_rst_n,
	output logic [NDOM-1:0]           dom_rst_n,
	output logic [NDOM*NBR-1:0]       br_rst_n,
	// status
	output logic                      seq_busy
);
	import src_pkg::*;

	src_state_e             st_q, st_d;
	logic [SRC_CNT_W-1:0]   cnt_q, cnt_d;
	logic [1:0]             ext_s_q;
	logic                   gwdt_s1_q, gwdt_s2_q;
	logic [NCPU-1:0]        cwdt_s1_q, cwdt_s2_q;
	logic                   glb_sw_q, gwdt_mask_q, func_static_q, dbg_q;
	logic [NCPU-1:0]        cpu_dbg_q, cwdt_mask_q;
	logic [NDOM-1:0]        dom_q;
	logic [NDOM*NBR-1:0]    br_q;
	logic [SRC_PULSE_W-1:0] fp_cnt_q;
	logic [SRC_PULSE_W-1:0] cw_cnt_q [NCPU];
	logic                   clk_rst_n_q, func_rst_n_q, dbg_rst_n_q, busy_q;
	logic [NCPU-1:0]        cpu_rst_n_q, cpu_dbg_rst_n_q, cwdt_hit;
	logic                   ext_ok, glb_hit, func_hold;

	// pin release is synchronised; assertion is not (flops reset on the pin)
	always_ff @(posedge clk or negedge ext_rst_n) begin
		if (!ext_rst_n) begin
			ext_s_q <= 2'b00;
		end else begin
			ext_s_q <= {ext_s_q[0], 1'b1};
		end
	end
	assign ext_ok = ext_s_q[1];

	always_ff @(posedge clk or negedge ext_rst_n) begin
		if (!ext_rst_n) begin
			gwdt_s1_q <= 1'b0;
			gwdt_s2_q <= 1'b0;
			cwdt_s1_q <= '0;
			cwdt_s2_q <= '0;
		end else begin
			gwdt_s1_q <= gwdt_exp;
			gwdt_s2_q <= gwdt_s1_q;
			cwdt_s1_q <= cpu_wdt_exp;
			cwdt_s2_q <= cwdt_s1_q;
		end
	end

	assign glb_hit   = glb_sw_q | (gwdt_s2_q & ~gwdt_mask_q);
	assign cwdt_hit  = cwdt_s2_q & ~cwdt_mask_q;
	assign func_hold = func_static_q | (fp_cnt_q != '0);

	// software bits; a global reset returns them to the same values as the pin does
	always_ff @(posedge clk or negedge ext_rst_n) begin
		if (!ext_rst_n) begin
			glb_sw_q      <= 1'b0;
			gwdt_mask_q   <= SRC_MASK_INIT;
			cwdt_mask_q   <= {NCPU{SRC_MASK_INIT}};
			func_static_q <= SRC_FUNC_INIT;
			dbg_q         <= SRC_DBG_INIT;
			cpu_dbg_q     <= {NCPU{SRC_DBG_INIT}};
			dom_q         <= {NDOM{SRC_DOM_INIT}};
			br_q          <= ~BOOT_MASK;
		end else if (!rst_n || glb_hit) begin
			glb_sw_q      <= 1'b0;
			gwdt_mask_q   <= SRC_MASK_INIT;
			cwdt_mask_q   <= {NCPU{SRC_MASK_INIT}};
			func_static_q <= SRC_FUNC_INIT;
			dbg_q         <= SRC_DBG_INIT;
			cpu_dbg_q     <= {NCPU{SRC_DBG_INIT}};
			dom_q         <= {NDOM{SRC_DOM_INIT}};
			br_q          <= ~BOOT_MASK;
		end else if (cfg_we) begin
			glb_sw_q      <= cfg_glb_sw_rst;
			gwdt_mask_q   <= cfg_gwdt_mask;
			cwdt_mask_q   <= cfg_cpu_wdt_mask;
			func_static_q <= cfg_func_static;
			dbg_q         <= cfg_dbg_rst;
			cpu_dbg_q     <= cfg_cpu_dbg_rst;
			dom_q         <= cfg_dom_rst;
			br_q          <= cfg_br_rst;
		end
	end

	// self-clearing functional reset length
	always_ff @(posedge clk or negedge ext_rst_n) begin
		if (!ext_rst_n) begin
			fp_cnt_q <= '0;
		end else if (!rst_n || glb_hit) begin
			fp_cnt_q <= '0;
		end else if (cfg_we && cfg_func_pulse) begin
			fp_cnt_q <= SRC_PULSE_W'(SRC_PULSE_CYCLES);
		end else if (fp_cnt_q != '0) begin
			fp_cnt_q <= fp_cnt_q - 1'b1;
		end
	end

	// per-core watchdog hold, counted after the expiry level drops
	for (genvar i = 0; i < NCPU; i++) begin : g_cwdt
		always_ff @(posedge clk or negedge ext_rst_n) begin
			if (!ext_rst_n) begin
				cw_cnt_q[i] <= '0;
			end else if (!rst_n || glb_hit) begin
				cw_cnt_q[i] <= '0;
			end else if (cwdt_hit[i]) begin
				cw_cnt_q[i] <= SRC_PULSE_W'(SRC_PULSE_CYCLES);
			end else if (cw_cnt_q[i] != '0) begin
				cw_cnt_q[i] <= cw_cnt_q[i] - 1'b1;
			end
		end
	end

	// release sequencer
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		if (!rst_n || !ext_ok || glb_hit) begin
			st_d  = SRC_ST_HOLD;
			cnt_d = '0;
		end else begin
			case (st_q)
				SRC_ST_HOLD: begin
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == SRC_CNT_W'(SRC_CLK_REL - 1)) begin
						st_d = SRC_ST_CLK;
					end
				end
				SRC_ST_CLK: begin
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == SRC_CNT_W'(SRC_FUNC_REL - 1)) begin
						st_d = SRC_ST_FUNC;
					end
				end
				SRC_ST_FUNC: begin
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == SRC_CNT_W'(SRC_SEQ_CYCLES - 1)) begin
						st_d = SRC_ST_RUN;
					end
				end
				SRC_ST_RUN: begin
					cnt_d = cnt_q;
				end
				default: begin
					st_d  = SRC_ST_HOLD;
					cnt_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge ext_rst_n) begin
		if (!ext_rst_n) begin
			st_q  <= SRC_ST_HOLD;
			cnt_q <= '0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
		end
	end

	// reset outputs follow the next state so each stage releases on its edge
	always_ff @(posedge clk or negedge ext_rst_n) begin
		if (!ext_rst_n) begin
			clk_rst_n_q     <= 1'b0;
			func_rst_n_q    <= 1'b0;
			cpu_rst_n_q     <= '0;
			dbg_rst_n_q     <= 1'b0;
			cpu_dbg_rst_n_q <= '0;
			busy_q          <= 1'b1;
		end else begin
			clk_rst_n_q  <= (st_d != SRC_ST_HOLD);
			func_rst_n_q <= (st_d == SRC_ST_FUNC || st_d == SRC_ST_RUN) && !func_hold;
			for (int i = 0; i < NCPU; i++) begin
				cpu_rst_n_q[i] <= (st_d == SRC_ST_RUN) && !func_hold && !cwdt_hit[i]
					&& (cw_cnt_q[i] == '0);
				cpu_dbg_rst_n_q[i] <= (st_d != SRC_ST_HOLD) && !dbg_q && !cpu_dbg_q[i];
			end
			dbg_rst_n_q <= (st_d != SRC_ST_HOLD) && !dbg_q;
			busy_q      <= (st_d != SRC_ST_RUN);
		end
	end

	// clock domains
	for (genvar d = 0; d < NDOM; d++) begin : g_dom
		src_dom_if #(.NBR(NBR)) dif ();
		assign dif.dom_clk = dom_clk[d];
		assign dif.dom_req = !func_rst_n_q || dom_q[d];
		assign dif.br_req  = br_q[d*NBR +: NBR];
		src_dom_sync #(.NBR(NBR)) u_sync (.dif(dif.sync));
		assign dom_rst_n[d]            = dif.dom_rst_n;
		assign br_rst_n[d*NBR +: NBR]  = dif.br_rst_n;
	end

	assign clk_logic_rst_n = clk_rst_n_q;
	assign func_rst_n      = func_rst_n_q;
	assign cpu_rst_n       = cpu_rst_n_q;
	assign dbg_rst_n       = dbg_rst_n_q;
	assign cpu_dbg_rst_n   = cpu_dbg_rst_n_q;
	assign seq_busy        = busy_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!ext_rst_n || !rst_n);

	sequence s_pulse_req;
		cfg_we && cfg_func_pulse && !glb_hit && st_q == SRC_ST_RUN;
	endsequence
	sequence s_func_low;
		(!func_rst_n_q) [*8];
	endsequence

	a_seq_length: assert property ($rose(st_q == SRC_ST_RUN) |-> cnt_q == SRC_CNT_W'(SRC_SEQ_CYCLES))
		else $error("release sequence length wrong");
	a_order_func: assert property ($rose(func_rst_n_q) |-> clk_rst_n_q)
		else $error("functional release before clocking release");
	a_order_cpu: assert property ($rose(cpu_rst_n_q[0]) |-> func_rst_n_q && clk_rst_n_q)
		else $error("core release before functional release");
	a_glb_restart: assert property (glb_hit |=> st_q == SRC_ST_HOLD && cnt_q == '0 && !clk_rst_n_q)
		else $error("global reset did not restart sequence");
	a_sw_selfclr: assert property (glb_sw_q |=> !glb_sw_q)
		else $error("global software bit did not clear");
	a_wdt_masked: assert property ((st_q == SRC_ST_RUN && gwdt_s2_q && gwdt_mask_q && !glb_sw_q
		&& ext_ok) |=> st_q == SRC_ST_RUN)
		else $error("masked watchdog caused reset");
	a_cpu_wdt_local: assert property ((cwdt_hit[0] && func_rst_n_q && !glb_hit && !cfg_we
		&& st_q == SRC_ST_RUN && !func_hold) |=> !cpu_rst_n_q[0] && func_rst_n_q)
		else $error("core watchdog not local");
	a_func_pulse: assert property (s_pulse_req |=> ##1 s_func_low)
		else $error("functional pulse too short");
	a_func_spares: assert property ((st_q == SRC_ST_RUN && func_hold && !glb_hit && !dbg_q)
		|=> !func_rst_n_q && clk_rst_n_q && dbg_rst_n_q)
		else $error("functional reset touched clock or debug");
	a_dbg_static: assert property (dbg_q |=> !dbg_rst_n_q && !cpu_dbg_rst_n_q[0])
		else $error("debug bit did not hold debug reset");
	a_cpu_dbg_own: assert property ((cpu_dbg_q[0] && !glb_hit) |=> !cpu_dbg_rst_n_q[0])
		else $error("core debug bit ignored");
endmodule // src_reset_ctrl

// >>> tb/src_board_sup.sv
// board reset supervisor model driving the reset pin
module src_board_sup #(
	parameter int unsigned HOLD_CYC = 200
) (
	// clock and supplies
	input  wire logic clk,
	input  wire logic pwr_good,
	// reset pin
	output logic      ext_rst_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned cnt_q;
	// pin drops at once on supply loss, releases after ten microseconds of running clock
	always @(posedge clk or negedge pwr_good) begin
		if (!pwr_good) begin
			cnt_q     <= 0;
			ext_rst_n <= 1'b0;
		end else if (cnt_q < HOLD_CYC) begin
			cnt_q <= cnt_q + 1;
		end else begin
			ext_rst_n <= 1'b1;
		end
	end
endmodule // src_board_sup

// >>> tb/src_reset_ctrl_tb_top.sv
// testbench for the reset controller
module src_reset_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import src_pkg::*;
	localparam logic [15:0] BOOT = 16'h0001;
	logic        clk = 0, rst_n = 0, pwr_good = 0, gwdt_exp = 0, cfg_we = 0;
	logic        cfg_glb_sw_rst = 0, cfg_func_pulse = 0, cfg_func_static = 0;
	logic        cfg_dbg_rst = 0, cfg_gwdt_mask = 0;
	logic [1:0]  cpu_wdt_exp = '0, cfg_cpu_dbg_rst = '0, cfg_cpu_wdt_mask = '0;
	logic [3:0]  cfg_dom_rst = '0, dom_clk = '0;
	logic [15:0] cfg_br_rst = ~BOOT;
	logic        ext_rst_n, clk_logic_rst_n, func_rst_n, dbg_rst_n, seq_busy;
	logic [1:0]  cpu_rst_n, cpu_dbg_rst_n;
	logic [3:0]  dom_rst_n;
	logic [15:0] br_rst_n;
	int          errors = 0, n_checks = 0, n;

	always #25 clk = ~clk;
	always #15 dom_clk[0] = ~dom_clk[0];
	always #35 dom_clk[1] = ~dom_clk[1];
	always #55 dom_clk[2] = ~dom_clk[2];
	always #65 dom_clk[3] = ~dom_clk[3];

	src_board_sup #(.HOLD_CYC(200)) src_board_sup_i (.clk, .pwr_good, .ext_rst_n);

	src_reset_ctrl #(.NCPU(2), .NDOM(4), .NBR(4), .BOOT_MASK(BOOT)) src_reset_ctrl_i (
		.clk, .rst_n, .ext_rst_n, .gwdt_exp, .cpu_wdt_exp, .cfg_we, .cfg_glb_sw_rst,
		.cfg_func_pulse, .cfg_func_static, .cfg_dbg_rst, .cfg_cpu_dbg_rst,
		.cfg_gwdt_mask, .cfg_cpu_wdt_mask, .cfg_dom_rst, .cfg_br_rst, .dom_clk,
		.clk_logic_rst_n, .func_rst_n, .cpu_rst_n, .dbg_rst_n, .cpu_dbg_rst_n,
		.dom_rst_n, .br_rst_n, .seq_busy);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask

	// one configuration write; pulse requests drop afterwards
	task automatic wr;
		cfg_we = 1'b1;
		cyc(1);
		cfg_we         = 1'b0;
		cfg_glb_sw_rst = 1'b0;
		cfg_func_pulse = 1'b0;
	endtask

	function automatic logic pick(input int k);
		case (k)
			0:       pick = clk_logic_rst_n;
			1:       pick = func_rst_n;
			default: pick = &cpu_rst_n;
		endcase
	endfunction

	task automatic wait_hi(input int k, output int w);
		w = 0;
		while (pick(k) !== 1'b1 && w < 400) begin
			cyc(1);
			w++;
		end
	endtask

	// follows one staged release and returns its length in cycles
	task automatic seq_chk(output int tot);
		int a, b, c;
		wait_hi(0, a);
		wait_hi(1, b);
		wait_hi(2, c);
		tot = a + b + c;
		chk(b, SRC_FUNC_REL - SRC_CLK_REL);
		chk(c, SRC_SEQ_CYCLES - SRC_FUNC_REL);
		chk(seq_busy, 1'b0);
		chk(dbg_rst_n, 1'b1);
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		#(50 * 20000);
		errors++;
		conclude();
	end

	initial begin
		cyc(4);
		rst_n    = 1'b1;
		pwr_good = 1'b1;
		seq_chk(n);
		cyc(4);
		chk(br_rst_n, BOOT);
		chk(dom_rst_n, 4'hf);
		done("power_up");
		pwr_good = 1'b0;
		#1;
		chk({clk_logic_rst_n, func_rst_n, cpu_rst_n, seq_busy}, 5'h01);
		cyc(2);
		pwr_good = 1'b1;
		seq_chk(n);
		done("board_reset");
		// internal synchronous reset restarts the same schedule from its edge
		rst_n = 1'b0;
		cyc(1);
		chk({clk_logic_rst_n, func_rst_n, cpu_rst_n, seq_busy}, 5'h01);
		rst_n = 1'b1;
		seq_chk(n);
		chk(n, SRC_SEQ_CYCLES);
		done("sync_reset");
		cfg_glb_sw_rst = 1'b1;
		wr();
		cyc(1);
		chk({clk_logic_rst_n, func_rst_n, cpu_rst_n}, 4'h0);
		seq_chk(n);
		chk(n, SRC_SEQ_CYCLES);
		cyc(20);
		chk(seq_busy, 1'b0);
		done("sw_global");
		cfg_gwdt_mask = 1'b1;
		wr();
		gwdt_exp = 1'b1;
		cyc(8);
		chk({clk_logic_rst_n, seq_busy}, 2'b10);
		// let the synchroniser drain before unmasking, else the old level fires
		gwdt_exp = 1'b0;
		cyc(3);
		cfg_gwdt_mask = 1'b0;
		wr();
		gwdt_exp = 1'b1;
		cyc(5);
		chk({clk_logic_rst_n, cpu_rst_n}, 3'h0);
		gwdt_exp = 1'b0;
		seq_chk(n);
		done("global_watchdog");
		cpu_wdt_exp = 2'b01;
		cyc(5);
		chk({func_rst_n, cpu_rst_n}, 3'b110);
		cpu_wdt_exp = 2'b00;
		cyc(SRC_PULSE_CYCLES + 6);
		chk(cpu_rst_n, 2'b11);
		cfg_cpu_wdt_mask = 2'b10;
		wr();
		cpu_wdt_exp = 2'b10;
		cyc(6);
		chk(cpu_rst_n, 2'b11);
		cpu_wdt_exp = 2'b00;
		cyc(3);
		cfg_cpu_wdt_mask = 2'b00;
		wr();
		done("core_watchdog");
		cfg_func_pulse = 1'b1;
		wr();
		cyc(1);
		chk({func_rst_n, cpu_rst_n, dom_rst_n}, 7'h00);
		chk({clk_logic_rst_n, dbg_rst_n}, 2'b11);
		wait_hi(1, n);
		chk(n, SRC_PULSE_CYCLES);
		cfg_func_static = 1'b1;
		wr();
		cyc(30);
		chk(func_rst_n, 1'b0);
		cfg_func_static = 1'b0;
		wr();
		cyc(10);
		chk(func_rst_n, 1'b1);
		done("functional");
		cfg_dbg_rst = 1'b1;
		wr();
		cyc(1);
		chk({dbg_rst_n, cpu_dbg_rst_n, func_rst_n}, 4'b0001);
		cfg_dbg_rst     = 1'b0;
		cfg_cpu_dbg_rst = 2'b01;
		wr();
		cyc(1);
		chk({dbg_rst_n, cpu_dbg_rst_n}, 3'b110);
		cfg_cpu_dbg_rst = 2'b00;
		wr();
		done("debug");
		// release all of domain 1 and branch 0 of domain 0, the rest stay held
		cfg_br_rst = 16'hff0e;
		wr();
		cyc(10);
		chk({dom_rst_n, br_rst_n}, {4'hf, 16'h00f1});
		// domain bit must pull its released branches back into reset
		cfg_dom_rst = 4'b0010;
		wr();
		cyc(1);
		chk({dom_rst_n, br_rst_n}, {4'b1101, 16'h0001});
		done("domains");
		conclude();
	end
endmodule // src_reset_ctrl_tb_top
